/* File: rtl/mspi_pkg.sv */
// Shared constants for the serial port run as a master-only SPI engine.
// Assumes a single system clock and that all users import the package.

package mspi_pkg;

  // ************************
  // Mode select and frame shape
  // ************************
  localparam logic [1:0] MODE_MASTER_SPI = 2'h3; // Both select bits set
  localparam int FRAME_BITS = 8;                 // One character per frame
  localparam logic [3:0] EDGE_FIRST = 4'h0;      // First clock edge of frame
  localparam logic [3:0] EDGE_LAST = 4'hF;       // Sixteenth clock edge

  // ************************
  // Baud divisor
  // ************************
  localparam int DIV_W = 12;                     // Divisor width
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000; // Divisor after reset
  localparam logic [DIV_W-1:0] DIV_ZERO = 12'h000;  // Terminal count

  // ************************
  // Reset values and receive queue
  // ************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;      // Cleared data byte
  localparam logic IDLE_DATA = 1'b1;             // Data line idle level
  localparam logic [1:0] RXQ_EMPTY = 2'h0;       // No unread bytes
  localparam logic [1:0] RXQ_ONE = 2'h1;         // One unread byte
  localparam logic [1:0] RXQ_FULL = 2'h2;        // Two unread bytes

  // ************************
  // Engine states
  // ************************
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,   // Waiting for a byte in the transmit buffer
    ST_SHIFT = 1'b1   // Clocking one frame
  } engine_state_t;

endpackage : mspi_pkg

/* File: rtl/mspi_baud_gen.sv */
// Half-period tick generator for the serial clock.
// Assumes the divisor is stable while run is high.

`timescale 1ns/1ps

module mspi_baud_gen
  import mspi_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [DIV_W-1:0] cnt_q; // Cycles left in this half period

  // ************************
  // Down counter, reloaded with the divisor
  // ************************
  // Half period is divisor plus one cycles, so a full serial
  // clock period is two times (divisor plus one) system cycles.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= DIV_RESET; // RL14
    end
    else if (!run || cnt_q == DIV_ZERO)
    begin
      cnt_q <= divisor; // RL3
    end
    else
    begin
      cnt_q <= cnt_q - 12'h001;
    end
  end

  // Tick marks each serial clock edge
  assign tick = run && (cnt_q == DIV_ZERO);

endmodule : mspi_baud_gen

/* File: rtl/mspi_pin_sync.sv */
// Three-stage synchroniser for a pin input.
// Assumes the pin is asynchronous to clk; output changes once
// the second and third stages agree.

`timescale 1ns/1ps

module mspi_pin_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  logic s1_q; // Metastability catcher, read only by s2_q
  logic s2_q; // Second stage
  logic s3_q; // Third stage

  // ************************
  // Synchroniser chain and agreement filter
  // ************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Accept only a settled value
      if (s2_q == s3_q)
      begin
        level <= s3_q;
      end
    end
  end

endmodule : mspi_pin_sync

/* File: rtl/mspi_master.sv */
// Serial port reused as a master-only SPI engine: clock generation,
// four data modes, 8-bit frames, buffered transmit and receive.
// Assumes control inputs come from logic on MCLK; the data-in pin
// is asynchronous and is synchronised here.
//
// Notes on behaviour
// RL1: Serial clock made internally only, master only.
// RL2: Software sets clock pin as output first.
// RL3: Clock rate is system clock over 2(div+1).
// RL4: Divisor is 12 bits from high and low.
// RL5: Polarity and phase pick one of four modes.
// RL6: Shift out and sample on opposite edges.
// RL7: Software keeps mode bits steady during transfers.
// RL8: Frame is eight data bits, no framing bits.
// RL9: One bit-order control for both directions.
// RL10: Next frame follows directly, else data idles high.
// RL11: Two writes send sixteen bits, then complete.
// RL12: Transmitter alone works; receiver needs transmitter.
// RL13: Software holds divisor zero while enabling transmitter.
// RL14: Divisor resets to zero.
// RL15: Software confirms idle before reconfiguring.
// RL16: Software clears complete flag before each write.
// RL17: Software keeps interrupts off during setup.
// RL18: Both mode-select bits set selects master SPI.
// RL19: Data write starts full-duplex byte transfer.
// RL20: Clock rests at polarity level between frames.

`timescale 1ns/1ps

module mspi_master
  import mspi_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [1:0] PORT_MODE_SELECT,
  input wire logic CLOCK_POLARITY_BIT,
  input wire logic CLOCK_PHASE_BIT,
  input wire logic BIT_ORDER_SELECT,
  input wire logic [3:0] BAUD_DIVISOR_HIGH,
  input wire logic [7:0] BAUD_DIVISOR_LOW,
  input wire logic TRANSMITTER_ENABLE,
  input wire logic RECEIVER_ENABLE,
  input wire logic [7:0] DATA_WRITE_BYTE,
  input wire logic DATA_WRITE,
  input wire logic DATA_READ,
  input wire logic TRANSMIT_COMPLETE_CLEAR,
  input wire logic SERIAL_DATA_IN,
  output logic SERIAL_CLOCK_PIN,
  output logic SERIAL_DATA_OUT,
  output logic [7:0] DATA_READ_BYTE,
  output logic RECEIVE_COMPLETE_FLAG,
  output logic TRANSMIT_COMPLETE_FLAG,
  output logic DATA_REGISTER_EMPTY,
  output logic TRANSFER_BUSY
);

  // ************************
  // Declarations
  // ************************
  logic spi_mode;             // Master SPI mode selected
  logic tx_on;                // Transmitter active in SPI mode
  logic rx_on;                // Receiver active, needs transmitter
  logic [DIV_W-1:0] divisor;  // Combined baud divisor
  logic tick;                 // One serial clock edge is due
  logic din;                  // Synchronised data-in level
  logic leading;              // Current edge is a leading edge
  logic sample_now;           // Sample data-in on this edge
  logic setup_now;            // Drive next data bit on this edge
  logic frame_end;            // Last edge of a frame
  logic load_next;            // Start a frame from the buffer
  logic first_bit;            // First bit of the buffered byte
  logic [7:0] rx_next;        // Receive shifter after this sample
  logic rx_push;              // Completed byte enters receive queue

  engine_state_t state_q;     // Engine state
  engine_state_t state_d;     // Next engine state
  logic [3:0] edge_q;         // Edge index within the frame
  logic [7:0] tx_buf_q;       // Transmit buffer
  logic tx_full_q;            // Transmit buffer holds a byte
  logic [7:0] tx_sh_q;        // Transmit shifter
  logic [7:0] rx_sh_q;        // Receive shifter
  logic [7:0] rx_spare_q;     // Second level of receive queue
  logic [1:0] rx_cnt_q;       // Unread bytes in receive queue

  // ************************
  // Mode decode and divisor
  // ************************
  assign spi_mode = (PORT_MODE_SELECT == MODE_MASTER_SPI); // RL18
  assign tx_on = spi_mode && TRANSMITTER_ENABLE;
  assign rx_on = tx_on && RECEIVER_ENABLE; // RL12
  assign divisor = {BAUD_DIVISOR_HIGH, BAUD_DIVISOR_LOW}; // RL4

  // ************************
  // Baud generator and input synchroniser
  // ************************
  // Only the internal generator clocks the link
  mspi_baud_gen u_baud // RL1
  (
    .clk(MCLK),
    .rst(RST),
    .run(state_q == ST_SHIFT),
    .divisor(divisor),
    .tick(tick)
  );

  // Data-in pin crosses into MCLK
  mspi_pin_sync u_din
  (
    .clk(MCLK),
    .rst(RST),
    .pin(SERIAL_DATA_IN),
    .level(din)
  );

  // ************************
  // Edge classification
  // ************************
  // Even edges are leading, odd ones trailing
  assign leading = ~edge_q[0];
  // Phase zero samples on leading, phase one on trailing
  assign sample_now = tick && (leading ^ CLOCK_PHASE_BIT); // RL5
  // Setup uses the other edge of each pair
  assign setup_now = tick && !(leading ^ CLOCK_PHASE_BIT); // RL6
  assign frame_end = tick && (edge_q == EDGE_LAST); // RL8
  // Back-to-back frame when the buffer is already filled
  assign load_next = tx_full_q && tx_on &&
                     ((state_q == ST_IDLE) || frame_end); // RL10
  // Bit order chooses which end leaves first
  assign first_bit = BIT_ORDER_SELECT ? tx_buf_q[0]
                                      : tx_buf_q[FRAME_BITS-1]; // RL9
  // Receive shifter fills from the same end order; off a sample
  // edge it holds, so a phase-zero frame end pushes the whole byte
  assign rx_next = !sample_now ? rx_sh_q
                 : BIT_ORDER_SELECT ? {din, rx_sh_q[7:1]}
                 : {rx_sh_q[6:0], din}; // RL9
  assign rx_push = frame_end && rx_on;

  // ************************
  // Engine state
  // ************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        // Buffered byte starts a transfer
        if (load_next)
        begin
          state_d = ST_SHIFT; // RL19
        end
      end
      ST_SHIFT:
      begin
        // Leaving the mode or transmitter aborts the frame
        if (!tx_on)
        begin
          state_d = ST_IDLE;
        end
        else if (frame_end && !load_next)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ************************
  // Edge counter
  // ************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      edge_q <= EDGE_FIRST;
    end
    else if (load_next || state_q == ST_IDLE)
    begin
      // Every frame starts at its first edge
      edge_q <= EDGE_FIRST;
    end
    else if (tick)
    begin
      // Wraps after sixteen edges, eight bits
      edge_q <= edge_q + 4'h1; // RL8
    end
  end

  // ************************
  // Serial clock output
  // ************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      SERIAL_CLOCK_PIN <= 1'b0;
    end
    else if (state_q != ST_SHIFT)
    begin
      // Rest at the polarity level between frames
      SERIAL_CLOCK_PIN <= CLOCK_POLARITY_BIT; // RL20
    end
    else if (tick)
    begin
      // Toggle once per half period
      SERIAL_CLOCK_PIN <= ~SERIAL_CLOCK_PIN; // RL3
    end
  end

  // ************************
  // Transmit buffer
  // ************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      tx_buf_q <= BYTE_ZERO;
      tx_full_q <= 1'b0;
    end
    else if (!tx_on)
    begin
      // Disabled transmitter drops a queued byte
      tx_full_q <= 1'b0;
    end
    else if (DATA_WRITE && (!tx_full_q || load_next))
    begin
      // Second write queues behind the shifting byte
      tx_buf_q <= DATA_WRITE_BYTE; // RL11
      tx_full_q <= 1'b1;
    end
    else if (load_next)
    begin
      // Byte moved into the shifter
      tx_full_q <= 1'b0;
    end
  end

  // ************************
  // Transmit shifter and data line
  // ************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      tx_sh_q <= BYTE_ZERO;
      SERIAL_DATA_OUT <= IDLE_DATA;
    end
    else if (load_next)
    begin
      if (!CLOCK_PHASE_BIT)
      begin
        // Phase zero: first bit stands before the first edge
        SERIAL_DATA_OUT <= first_bit; // RL5
        tx_sh_q <= BIT_ORDER_SELECT ? {1'b0, tx_buf_q[7:1]}
                                    : {tx_buf_q[6:0], 1'b0};
      end
      else
      begin
        // Phase one: first bit goes out on the leading edge
        tx_sh_q <= tx_buf_q;
      end
    end
    else if (state_q != ST_SHIFT || frame_end)
    begin
      // Line idles high after the last frame
      SERIAL_DATA_OUT <= IDLE_DATA; // RL10
    end
    else if (setup_now && !(CLOCK_PHASE_BIT == 1'b0 &&
                            edge_q == EDGE_LAST))
    begin
      // Shift out on the setup edge only
      SERIAL_DATA_OUT <= BIT_ORDER_SELECT ? tx_sh_q[0]
                                          : tx_sh_q[7]; // RL6
      tx_sh_q <= BIT_ORDER_SELECT ? {1'b0, tx_sh_q[7:1]}
                                  : {tx_sh_q[6:0], 1'b0};
    end
  end

  // ************************
  // Receive shifter
  // ************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      rx_sh_q <= BYTE_ZERO;
    end
    else if (sample_now && state_q == ST_SHIFT)
    begin
      // Latch on the sampling edge
      rx_sh_q <= rx_next; // RL6
    end
  end

  // ************************
  // Receive queue, two levels
  // ************************
  // On overflow the newest byte is lost, queued ones stay.
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      DATA_READ_BYTE <= BYTE_ZERO;
      rx_spare_q <= BYTE_ZERO;
      rx_cnt_q <= RXQ_EMPTY;
    end
    else if (!rx_on)
    begin
      // Disabled receiver flushes the queue
      rx_cnt_q <= RXQ_EMPTY;
    end
    else if (DATA_READ && rx_cnt_q != RXQ_EMPTY)
    begin
      if (rx_cnt_q == RXQ_FULL)
      begin
        DATA_READ_BYTE <= rx_spare_q;
        if (rx_push)
        begin
          rx_spare_q <= rx_next;
        end
        else
        begin
          rx_cnt_q <= RXQ_ONE;
        end
      end
      else if (rx_push)
      begin
        // Pop and push together keep one byte
        DATA_READ_BYTE <= rx_next;
      end
      else
      begin
        rx_cnt_q <= RXQ_EMPTY;
      end
    end
    else if (rx_push)
    begin
      // Byte received while sending
      if (rx_cnt_q == RXQ_EMPTY)
      begin
        DATA_READ_BYTE <= rx_next; // RL19
        rx_cnt_q <= RXQ_ONE;
      end
      else if (rx_cnt_q == RXQ_ONE)
      begin
        rx_spare_q <= rx_next;
        rx_cnt_q <= RXQ_FULL;
      end
    end
  end

  // ************************
  // Status flags
  // ************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      TRANSMIT_COMPLETE_FLAG <= 1'b0;
    end
    else if (frame_end && !tx_full_q)
    begin
      // Set only when nothing waits; set beats clear
      TRANSMIT_COMPLETE_FLAG <= 1'b1; // RL11
    end
    else if (TRANSMIT_COMPLETE_CLEAR)
    begin
      TRANSMIT_COMPLETE_FLAG <= 1'b0;
    end
  end

  // Mirrors of internal state, all registered
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      RECEIVE_COMPLETE_FLAG <= 1'b0;
      DATA_REGISTER_EMPTY <= 1'b1;
      TRANSFER_BUSY <= 1'b0;
    end
    else
    begin
      RECEIVE_COMPLETE_FLAG <= rx_on && (rx_cnt_q != RXQ_EMPTY);
      DATA_REGISTER_EMPTY <= !tx_full_q;
      TRANSFER_BUSY <= (state_q == ST_SHIFT);
    end
  end

endmodule : mspi_master

/* File: test/mspi_master_props.sv */
// Checker for the master serial engine: clock, data line and flags.
// Assumes it is bound into mspi_master and sees only its ports.
`timescale 1ns/1ps
module mspi_master_props
  import mspi_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [1:0] PORT_MODE_SELECT,
  input wire logic CLOCK_POLARITY_BIT,
  input wire logic CLOCK_PHASE_BIT,
  input wire logic [3:0] BAUD_DIVISOR_HIGH,
  input wire logic [7:0] BAUD_DIVISOR_LOW,
  input wire logic TRANSMITTER_ENABLE,
  input wire logic RECEIVER_ENABLE,
  input wire logic DATA_WRITE,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic RECEIVE_COMPLETE_FLAG,
  input wire logic TRANSMIT_COMPLETE_FLAG,
  input wire logic DATA_REGISTER_EMPTY,
  input wire logic TRANSFER_BUSY
);
  // ************************
  // Edge tracking helpers
  // ************************
  logic sck_q; // Clock pin one cycle ago
  logic pol_q; // Polarity one cycle ago
  logic pol_q2; // Polarity two cycles ago
  logic [12:0] gap_q; // Cycles since the last clock edge
  logic [3:0] edge_q; // Edges seen in the current frame
  wire chg = SERIAL_CLOCK_PIN != sck_q;
  wire pol_ok = CLOCK_POLARITY_BIT == pol_q && pol_q == pol_q2;
  wire [3:0] edge_nx = edge_q + {3'h0, chg && pol_ok};
  wire [12:0] div = {1'b0, BAUD_DIVISOR_HIGH, BAUD_DIVISOR_LOW};
  wire lead = SERIAL_CLOCK_PIN != CLOCK_POLARITY_BIT;
  wire spi_on = TRANSMITTER_ENABLE && PORT_MODE_SELECT == MODE_MASTER_SPI;
  // History of clock pin and polarity
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sck_q <= 1'b0;
      pol_q <= 1'b0;
      pol_q2 <= 1'b0;
    end
    else
    begin
      sck_q <= SERIAL_CLOCK_PIN;
      pol_q <= CLOCK_POLARITY_BIT;
      pol_q2 <= pol_q;
    end
  end
  // Gap and edge counters; a polarity change is not a frame edge
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      gap_q <= 13'h0000;
      edge_q <= 4'h0;
    end
    else
    begin
      gap_q <= chg ? 13'h0000 : gap_q + 13'h0001;
      edge_q <= edge_nx;
    end
  end
  // ************************
  // Properties
  // ************************
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // Engine enabled, nothing queued, nothing shifting
  sequence s_quiet;
    (!TRANSFER_BUSY && DATA_REGISTER_EMPTY && spi_on && pol_ok) [*3];
  endsequence
  // An accepted write
  sequence s_write;
    DATA_WRITE && DATA_REGISTER_EMPTY && spi_on;
  endsequence
  chk_idle_clock_level:
    assert property (s_quiet |-> SERIAL_CLOCK_PIN == CLOCK_POLARITY_BIT)
    else $error("Clock pin not at idle level");
  chk_idle_data_high:
    assert property (s_quiet |-> SERIAL_DATA_OUT)
    else $error("Data line not idle high");
  chk_half_period_count:
    assert property (chg && pol_ok && edge_q != 4'h0 |-> gap_q == div)
    else $error("Clock half period differs from divisor plus one");
  chk_frame_edge_count:
    assert property ($fell(TRANSFER_BUSY) |-> edge_nx == 4'h0)
    else $error("Frame did not hold sixteen clock edges");
  chk_sample_edge_stable:
    assert property (chg && pol_ok && (lead != CLOCK_PHASE_BIT)
      && edge_q != 4'h0 && edge_q != 4'hF |-> $stable(SERIAL_DATA_OUT))
    else $error("Data line moved on a sample edge");
  chk_write_taken:
    assert property (s_write |-> ##[1:2] !DATA_REGISTER_EMPTY)
    else $error("Accepted write left buffer empty");
  chk_write_refused:
    assert property (DATA_WRITE && !spi_on && DATA_REGISTER_EMPTY
      && !TRANSFER_BUSY |=> (DATA_REGISTER_EMPTY && !TRANSFER_BUSY) [*3])
    else $error("Write taken while engine disabled");
  chk_txc_needs_empty:
    assert property ($rose(TRANSMIT_COMPLETE_FLAG) |-> DATA_REGISTER_EMPTY)
    else $error("Complete flag set with a byte still queued");
  chk_rx_off_quiet:
    assert property (!RECEIVER_ENABLE [*3] |-> !RECEIVE_COMPLETE_FLAG)
    else $error("Receive flag set with receiver off");
endmodule : mspi_master_props

bind mspi_master mspi_master_props u_props (
  .MCLK(MCLK), .RST(RST), .PORT_MODE_SELECT(PORT_MODE_SELECT),
  .CLOCK_POLARITY_BIT(CLOCK_POLARITY_BIT),
  .CLOCK_PHASE_BIT(CLOCK_PHASE_BIT),
  .BAUD_DIVISOR_HIGH(BAUD_DIVISOR_HIGH),
  .BAUD_DIVISOR_LOW(BAUD_DIVISOR_LOW),
  .TRANSMITTER_ENABLE(TRANSMITTER_ENABLE),
  .RECEIVER_ENABLE(RECEIVER_ENABLE), .DATA_WRITE(DATA_WRITE),
  .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .RECEIVE_COMPLETE_FLAG(RECEIVE_COMPLETE_FLAG),
  .TRANSMIT_COMPLETE_FLAG(TRANSMIT_COMPLETE_FLAG),
  .DATA_REGISTER_EMPTY(DATA_REGISTER_EMPTY),
  .TRANSFER_BUSY(TRANSFER_BUSY));

/* File: test/mspi_slave_model.sv */
// Behavioural slave on the far side of the serial link.
// Assumes it watches the link on the system clock; sel acts as select.
`timescale 1ns/1ps
module mspi_slave_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sel, // Slave selected by the bench
  input wire logic sck,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb, // Least significant bit first
  input wire logic [7:0] reply, // Byte sent back
  output logic miso,
  output logic [7:0] got, // Last whole byte received
  output logic [7:0] frames // Bytes received
);
  logic sck_q; // Clock one cycle ago
  logic mosi_q; // Data out as it stood before the edge
  logic [2:0] cnt_q; // Bits sampled in this frame
  logic [7:0] sh_q; // Receive shift register
  logic [7:0] sh_d; // Shift register with the new bit
  wire samp = (sck != cpol) != cpha;
  wire edge_seen = sel && sck != sck_q;
  // Next shift value in the chosen order
  always_comb sh_d = lsb ? {mosi_q, sh_q[7:1]} : {sh_q[6:0], mosi_q};
  // Reply bit for a given position
  function automatic logic pick(input logic [2:0] n);
    return lsb ? reply[n] : reply[3'h7 - n];
  endfunction : pick
  // Sample on one edge, set up on the other
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      mosi_q <= 1'b1;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      miso <= 1'b0;
      got <= 8'h00;
      frames <= 8'h00;
    end
    else
    begin
      sck_q <= sck;
      mosi_q <= mosi;
      if (!sel)
      begin
        cnt_q <= 3'h0;
        miso <= ~miso; // Released line keeps moving
      end
      else if (edge_seen && samp)
      begin
        sh_q <= sh_d;
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7)
        begin
          got <= sh_d;
          frames <= frames + 8'h01;
        end
      end
      else if (edge_seen || (cnt_q == 3'h0 && !cpha))
        miso <= pick(cnt_q);
    end
  end
endmodule : mspi_slave_model

/* File: test/mspi_master_tb.sv */
// Self-checking bench for the master serial engine.
// Assumes the slave model and the bound checker are compiled with it.
`timescale 1ns/1ps
module mspi_master_tb;
  import mspi_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [1:0] PORT_MODE_SELECT = 2'h0;
  logic CLOCK_POLARITY_BIT = 1'b0, CLOCK_PHASE_BIT = 1'b0;
  logic BIT_ORDER_SELECT = 1'b0, TRANSMITTER_ENABLE = 1'b0;
  logic [3:0] BAUD_DIVISOR_HIGH = 4'h0;
  logic [7:0] BAUD_DIVISOR_LOW = 8'h00, DATA_WRITE_BYTE = 8'h00;
  logic RECEIVER_ENABLE = 1'b0, DATA_WRITE = 1'b0, DATA_READ = 1'b0;
  logic TRANSMIT_COMPLETE_CLEAR = 1'b0, sel = 1'b0;
  logic SERIAL_DATA_IN, SERIAL_CLOCK_PIN, SERIAL_DATA_OUT;
  logic RECEIVE_COMPLETE_FLAG, TRANSMIT_COMPLETE_FLAG;
  logic DATA_REGISTER_EMPTY, TRANSFER_BUSY;
  logic [7:0] DATA_READ_BYTE, got, frames, n0;
  logic [7:0] reply = 8'h00;
  int errors = 0;
  int n_tests = 0;
  // Design under test and the slave on its link
  mspi_master u_dut (.MCLK(MCLK), .RST(RST),
    .PORT_MODE_SELECT(PORT_MODE_SELECT),
    .CLOCK_POLARITY_BIT(CLOCK_POLARITY_BIT),
    .CLOCK_PHASE_BIT(CLOCK_PHASE_BIT), .BIT_ORDER_SELECT(BIT_ORDER_SELECT),
    .BAUD_DIVISOR_HIGH(BAUD_DIVISOR_HIGH),
    .BAUD_DIVISOR_LOW(BAUD_DIVISOR_LOW),
    .TRANSMITTER_ENABLE(TRANSMITTER_ENABLE),
    .RECEIVER_ENABLE(RECEIVER_ENABLE), .DATA_WRITE_BYTE(DATA_WRITE_BYTE),
    .DATA_WRITE(DATA_WRITE), .DATA_READ(DATA_READ),
    .TRANSMIT_COMPLETE_CLEAR(TRANSMIT_COMPLETE_CLEAR),
    .SERIAL_DATA_IN(SERIAL_DATA_IN), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN),
    .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .DATA_READ_BYTE(DATA_READ_BYTE),
    .RECEIVE_COMPLETE_FLAG(RECEIVE_COMPLETE_FLAG),
    .TRANSMIT_COMPLETE_FLAG(TRANSMIT_COMPLETE_FLAG),
    .DATA_REGISTER_EMPTY(DATA_REGISTER_EMPTY),
    .TRANSFER_BUSY(TRANSFER_BUSY));
  mspi_slave_model u_slave (.mclk(MCLK), .rst(RST), .sel(sel),
    .sck(SERIAL_CLOCK_PIN), .mosi(SERIAL_DATA_OUT),
    .cpol(CLOCK_POLARITY_BIT), .cpha(CLOCK_PHASE_BIT),
    .lsb(BIT_ORDER_SELECT), .reply(reply), .miso(SERIAL_DATA_IN),
    .got(got), .frames(frames));
  // 100 MHz system clock
  always #5 MCLK = ~MCLK;
  // ************************
  // Access and compare tasks
  // ************************
  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : step
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_flag(input string what, input logic exp,
                            input logic seen);
    check(what, {7'h00, exp}, {7'h00, seen});
  endtask : check_flag
  // Wait for the receive or the transmit complete flag, bounded
  task automatic wait_flag(input logic rx);
    int n;
    n = 0;
    while ((rx ? RECEIVE_COMPLETE_FLAG : TRANSMIT_COMPLETE_FLAG) !== 1'b1
           && n < 9000)
    begin
      step(1);
      n++;
    end
    check_flag(rx ? "receive flag" : "transmit flag", 1'b1, n < 9000);
  endtask : wait_flag
  task automatic send(input logic [7:0] b);
    DATA_WRITE_BYTE = b;
    DATA_WRITE = 1'b1;
    step(1);
    DATA_WRITE = 1'b0;
  endtask : send
  task automatic read_rx(input logic [7:0] exp);
    wait_flag(1'b1);
    check("read byte", exp, DATA_READ_BYTE);
    DATA_READ = 1'b1;
    step(1);
    DATA_READ = 1'b0;
    step(2);
  endtask : read_rx
  // One byte out with the slave selected, then the byte the slave got is checked
  task automatic xfer(input logic [7:0] tx, input logic [7:0] rep);
    reply = rep;
    sel = 1'b1;
    step(2);
    send(tx);
    wait_flag(1'b0);
    step(2);
    check("slave byte", tx, got);
  endtask : xfer
  task automatic finish_xfer;
    TRANSMIT_COMPLETE_CLEAR = 1'b1;
    step(1);
    check_flag("complete cleared", 1'b0, TRANSMIT_COMPLETE_FLAG);
    TRANSMIT_COMPLETE_CLEAR = 1'b0;
    sel = 1'b0;
    step(2);
  endtask : finish_xfer
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Watchdog against a hung handshake
  initial
  begin
    #500000;
    errors++;
    $display("[FAIL] run time expected done seen timeout");
    final_report();
  end
  // ************************
  // Test sequence
  // ************************
  initial
  begin
    step(10);
    check_flag("reset clock pin", 1'b0, SERIAL_CLOCK_PIN);
    check_flag("reset data line", 1'b1, SERIAL_DATA_OUT);
    check_flag("reset buffer empty", 1'b1, DATA_REGISTER_EMPTY);
    RST = 1'b0;
    step(2);
    PORT_MODE_SELECT = MODE_MASTER_SPI;
    TRANSMITTER_ENABLE = 1'b1;
    RECEIVER_ENABLE = 1'b1;
    step(2);
    BAUD_DIVISOR_LOW = 8'h07;
    step(2);
    $display("test init done");
    for (int m = 0; m < 8; m++)
    begin
      {BIT_ORDER_SELECT, CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT} = m[2:0];
      step(4);
      xfer(8'hB1 + 8'(m), 8'h4E ^ 8'(m << 4));
      read_rx(8'h4E ^ 8'(m << 4));
      finish_xfer();
    end
    $display("test modes done");
    {BIT_ORDER_SELECT, CLOCK_POLARITY_BIT, CLOCK_PHASE_BIT} = 3'h0;
    reply = 8'h5A;
    sel = 1'b1;
    step(4);
    n0 = frames;
    DATA_WRITE_BYTE = 8'hC3;
    DATA_WRITE = 1'b1;
    step(1);
    DATA_WRITE_BYTE = 8'h3C;
    step(1);
    DATA_WRITE = 1'b0;
    for (int i = 0; i < 3000 && frames === n0; i++)
      step(1);
    check("first of pair", 8'hC3, got);
    step(4);
    check_flag("complete mid pair", 1'b0, TRANSMIT_COMPLETE_FLAG);
    wait_flag(1'b0);
    check("second of pair", 8'h3C, got);
    read_rx(8'h5A);
    read_rx(8'h5A);
    finish_xfer();
    $display("test pair done");
    sel = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      TRANSMITTER_ENABLE = (k == 1);
      PORT_MODE_SELECT = (k == 1) ? 2'h2 : MODE_MASTER_SPI;
      n0 = frames;
      step(2);
      send(8'h11);
      step(40);
      check_flag("buffer empty", 1'b1, DATA_REGISTER_EMPTY);
      check("frames sent", n0, frames);
    end
    TRANSMITTER_ENABLE = 1'b1;
    PORT_MODE_SELECT = MODE_MASTER_SPI;
    RECEIVER_ENABLE = 1'b0;
    BAUD_DIVISOR_LOW = 8'h00;
    step(4);
    xfer(8'h6D, 8'hFF);
    check_flag("receive flag off", 1'b0, RECEIVE_COMPLETE_FLAG);
    finish_xfer();
    RECEIVER_ENABLE = 1'b1;
    BAUD_DIVISOR_HIGH = 4'h1;
    step(4);
    xfer(8'h81, 8'h24);
    read_rx(8'h24);
    finish_xfer();
    $display("test divisor done");
    final_report();
  end
endmodule : mspi_master_tb
